// ==== hw/dacc_cal_seq.sv ====
// Purpose: offset calibration sequencer for one channel
// Assumes: start is a one-cycle pulse
// Notes: done pulses once when the fixed calibration time has elapsed
`include "dacc_defs.svh"
module dacc_cal_seq
    import dacc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    localparam logic [9:0] CAL_LAST = 10'(`DACC_CAL_CYCLES - 1);

    dacc_cal_state_t s;
    dacc_cal_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            DACC_CAL_IDLE: begin
                if (start_in) begin
                    next_s.st = DACC_CAL_RUN;
                    next_s.cnt = 10'h000;
                    next_s.busy = 1'b1;
                end
            end
            DACC_CAL_RUN: begin
                if (s.cnt == CAL_LAST) begin
                    next_s.st = DACC_CAL_DONE;
                    next_s.done = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + 10'h001;
                end
            end
            DACC_CAL_DONE: begin
                next_s.st = DACC_CAL_IDLE;
                next_s.busy = 1'b0;
            end
            default: begin
                next_s = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy_out = s.busy;
    assign done_out = s.done;
endmodule

// ==== hw/dacc_chan_decode.sv ====
// Purpose: decode one channel's control word and latched sample for the core
// Assumes: purely combinational, registered by the caller
// Notes: two's complement is turned into offset binary by inverting the sign
`include "dacc_defs.svh"
module dacc_chan_decode
    import dacc_pkg::*;
(
    input wire logic [15:0] ctl_in,
    input wire logic [11:0] latch_in,
    input wire logic cal_busy_in,
    output dacc_core_t core_out
);
    logic [2:0] amp;
    logic is_8bit;
    logic twos;

    always_comb begin
        amp = ctl_in[`DACC_B_AMP_HI:`DACC_B_AMP_LO];
        is_8bit = ctl_in[`DACC_B_RES];
        twos = ctl_in[`DACC_B_DF];
        core_out = '0;
        core_out.ref_sel = ctl_in[`DACC_B_SREF_HI:`DACC_B_SREF_LO];
        core_out.range_3x = ~ctl_in[`DACC_B_IR];
        core_out.res_8bit = is_8bit;
        core_out.cal_active = cal_busy_in;
        if (is_8bit) begin
            // upper nibble ignored, bit 7 is msb and sign
            core_out.code = {4'h0, latch_in[7] ^ twos, latch_in[6:0]};
        end else begin
            // right-justified, bit 11 is msb and sign
            core_out.code = {latch_in[11] ^ twos, latch_in[10:0]};
        end
        case (amp)
            3'b000: begin
                core_out.out_hiz = 1'b1;
            end
            3'b001: begin
                core_out.out_zero = 1'b1;
            end
            3'b010: begin
                core_out.in_spd = DACC_SPD_LOW;
                core_out.out_spd = DACC_SPD_LOW;
            end
            3'b011: begin
                core_out.in_spd = DACC_SPD_LOW;
                core_out.out_spd = DACC_SPD_MED;
            end
            3'b100: begin
                core_out.in_spd = DACC_SPD_LOW;
                core_out.out_spd = DACC_SPD_HIGH;
            end
            3'b101: begin
                core_out.in_spd = DACC_SPD_MED;
                core_out.out_spd = DACC_SPD_MED;
            end
            3'b110: begin
                core_out.in_spd = DACC_SPD_MED;
                core_out.out_spd = DACC_SPD_HIGH;
            end
            3'b111: begin
                core_out.in_spd = DACC_SPD_HIGH;
                core_out.out_spd = DACC_SPD_HIGH;
            end
            default: begin
                core_out.out_hiz = 1'b1;
            end
        endcase
    end
endmodule

// ==== hw/dacc_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz system clock, APB byte addresses
// Notes: definitions only
`ifndef DACC_DEFS_SVH
`define DACC_DEFS_SVH

`define DACC_OFF_CTL0 12'h000
`define DACC_OFF_DAT0 12'h004
`define DACC_OFF_CTL1 12'h008
`define DACC_OFF_DAT1 12'h00C
`define DACC_OFF_STAT 12'h010
`define DACC_OFF_MASK 12'h014

`define DACC_B_GRP 0
`define DACC_B_ENC 1
`define DACC_B_IFG 2
`define DACC_B_IE 3
`define DACC_B_DF 4
`define DACC_B_AMP_LO 5
`define DACC_B_AMP_HI 7
`define DACC_B_IR 8
`define DACC_B_CAL 9
`define DACC_B_LSEL_LO 10
`define DACC_B_LSEL_HI 11
`define DACC_B_RES 12
`define DACC_B_SREF_LO 13
`define DACC_B_SREF_HI 14

`define DACC_CTL_LOCK_MASK 16'h7DF1
`define DACC_CTL_RW_MASK 16'h7FFF
`define DACC_CTL_RST 16'h0000
`define DACC_DAT_RST 12'h000
`define DACC_MASK_RST 2'h3

`define DACC_LSEL_WRITE 2'h0
`define DACC_LSEL_GROUP 2'h1
`define DACC_LSEL_TMR1 2'h2
`define DACC_LSEL_TMR2 2'h3

`define DACC_CLK_PERIOD_NS 100
`define DACC_CAL_TIME_NS 100000
`define DACC_CAL_CYCLES ((`DACC_CAL_TIME_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)

`endif

// ==== hw/dacc_pkg.sv ====
// Purpose: types shared by the converter channel control logic
// Assumes: two channels
// Notes: constants live in dacc_defs.svh
package dacc_pkg;

    typedef enum logic [1:0] {
        DACC_SPD_OFF = 2'b00,
        DACC_SPD_LOW = 2'b01,
        DACC_SPD_MED = 2'b10,
        DACC_SPD_HIGH = 2'b11
    } dacc_speed_t;

    typedef enum logic [1:0] {
        DACC_CAL_IDLE = 2'b00,
        DACC_CAL_RUN = 2'b01,
        DACC_CAL_DONE = 2'b10
    } dacc_cal_st_t;

    typedef struct packed {
        logic [11:0] code;
        dacc_speed_t in_spd;
        dacc_speed_t out_spd;
        logic out_hiz;
        logic out_zero;
        logic [1:0] ref_sel;
        logic range_3x;
        logic res_8bit;
        logic cal_active;
    } dacc_core_t;

    typedef struct packed {
        dacc_cal_st_t st;
        logic [9:0] cnt;
        logic busy;
        logic done;
    } dacc_cal_state_t;

    typedef struct packed {
        logic [1:0][15:0] ctl;
        logic [1:0][11:0] dat;
        logic [1:0][11:0] latch;
        logic [1:0] pend;
        logic [1:0] mask;
        logic t1_prev;
        logic t2_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic [1:0] chan_irq;
        dacc_core_t [1:0] core;
    } dacc_top_state_t;

endpackage

// ==== hw/dacc_top.sv ====
// Purpose: control and data registers of a two-channel 12-bit converter
// Assumes: APB slave, 10 MHz clock, timer outputs synchronous to the clock
// Notes: channel 0 may be grouped with channel 1
//
// Our own choices: the placing of the registers and the APB slave port.
`include "dacc_defs.svh"
module dacc_top
    import dacc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic first_timer_out1_in,
    input wire logic second_timer_out2_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output logic [1:0] chan_irq_out,
    output dacc_core_t [1:0] core_out
);
    dacc_top_state_t s;
    dacc_top_state_t next_s;

    logic [1:0] cal_start;
    logic [1:0] cal_busy;
    logic [1:0] cal_done;
    dacc_core_t [1:0] core_dec;

    // true when the address is one of the six mapped words
    function automatic logic addr_mapped(input logic [11:0] a);
        case (a)
            `DACC_OFF_CTL0, `DACC_OFF_DAT0, `DACC_OFF_CTL1, `DACC_OFF_DAT1,
            `DACC_OFF_STAT, `DACC_OFF_MASK: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [11:0] ctl_off(input int ch);
        ctl_off = (ch == 0) ? `DACC_OFF_CTL0 : `DACC_OFF_CTL1;
    endfunction

    function automatic logic [11:0] dat_off(input int ch);
        dat_off = (ch == 0) ? `DACC_OFF_DAT0 : `DACC_OFF_DAT1;
    endfunction

    // enabled when load select is zero, or conversion enable is set
    function automatic logic chan_enabled(input logic [15:0] c);
        if (c[`DACC_B_LSEL_HI:`DACC_B_LSEL_LO] == `DACC_LSEL_WRITE) begin
            chan_enabled = 1'b1;
        end else begin
            chan_enabled = c[`DACC_B_ENC];
        end
    endfunction

    // trigger chosen by load select for a single channel
    function automatic logic chan_trig(input logic [15:0] c, input logic wr,
                                       input logic r1, input logic r2);
        case (c[`DACC_B_LSEL_HI:`DACC_B_LSEL_LO])
            `DACC_LSEL_WRITE: chan_trig = wr;
            `DACC_LSEL_GROUP: chan_trig = wr;
            `DACC_LSEL_TMR1: chan_trig = r1;
            `DACC_LSEL_TMR2: chan_trig = r2;
            default: chan_trig = 1'b0;
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            dacc_chan_decode u_dec (
                .ctl_in(s.ctl[gi]),
                .latch_in(s.latch[gi]),
                .cal_busy_in(cal_busy[gi]),
                .core_out(core_dec[gi])
            );
            dacc_cal_seq u_cal (
                .sys_clk_in(sys_clk_in),
                .nrst_in(nrst_in),
                .start_in(cal_start[gi]),
                .busy_out(cal_busy[gi]),
                .done_out(cal_done[gi])
            );
        end
    endgenerate

    logic acc_phase;
    logic wr_done;
    logic [1:0] wr_ctl;
    logic [1:0] wr_dat;
    logic [1:0] load;
    logic [1:0] flags;
    logic rise1;
    logic rise2;
    logic grouped;
    logic all_written;
    logic grp_trig;
    logic [15:0] wd;
    logic [15:0] cand;

    always_comb begin
        next_s = s;
        cal_start = 2'b00;
        load = 2'b00;
        wd = pwdata_in[15:0];
        cand = 16'h0000;
        all_written = 1'b0;
        grp_trig = 1'b0;
        acc_phase = psel_in & penable_in & ~s.pready;
        wr_done = psel_in & penable_in & s.pready & pwrite_in;
        rise1 = first_timer_out1_in & ~s.t1_prev;
        rise2 = second_timer_out2_in & ~s.t2_prev;
        next_s.t1_prev = first_timer_out1_in;
        next_s.t2_prev = second_timer_out2_in;
        // one wait state, then a one-cycle answer
        next_s.pready = acc_phase;
        next_s.pslverr = acc_phase & ~addr_mapped(paddr_in);
        if (acc_phase) begin
            case (paddr_in)
                `DACC_OFF_CTL0: next_s.prdata = {16'h0000, s.ctl[0]};
                `DACC_OFF_CTL1: next_s.prdata = {16'h0000, s.ctl[1]};
                `DACC_OFF_DAT0: next_s.prdata = {20'h00000, s.dat[0]};
                `DACC_OFF_DAT1: next_s.prdata = {20'h00000, s.dat[1]};
                `DACC_OFF_STAT: next_s.prdata = {30'h0, s.ctl[1][`DACC_B_IFG],
                                                 s.ctl[0][`DACC_B_IFG]};
                `DACC_OFF_MASK: next_s.prdata = {30'h0, s.mask};
                default: next_s.prdata = 32'h00000000;
            endcase
        end
        for (int i = 0; i < 2; i++) begin
            wr_ctl[i] = wr_done & (paddr_in == ctl_off(i));
            wr_dat[i] = wr_done & (paddr_in == dat_off(i));
            if (wr_ctl[i]) begin
                cand = wd & `DACC_CTL_RW_MASK;
                if (s.ctl[i][`DACC_B_ENC]) begin
                    // protected fields keep their value while enabled
                    cand = (s.ctl[i] & `DACC_CTL_LOCK_MASK) |
                           (cand & ~`DACC_CTL_LOCK_MASK);
                end
                cand[`DACC_B_CAL] = s.ctl[i][`DACC_B_CAL] | wd[`DACC_B_CAL];
                cal_start[i] = wd[`DACC_B_CAL] & ~s.ctl[i][`DACC_B_CAL];
                next_s.ctl[i] = cand;
            end
            if (wr_dat[i]) begin
                next_s.dat[i] = wd[11:0];
            end
            if (cal_done[i]) begin
                next_s.ctl[i][`DACC_B_CAL] = 1'b0;
            end
        end
        if (wr_done & (paddr_in == `DACC_OFF_STAT)) begin
            for (int i = 0; i < 2; i++) begin
                if (pwdata_in[i]) begin
                    next_s.ctl[i][`DACC_B_IFG] = 1'b0;
                end
            end
        end
        if (wr_done & (paddr_in == `DACC_OFF_MASK)) begin
            next_s.mask = pwdata_in[1:0];
        end
        // only channel 0 can group; channel 1 has no higher partner
        grouped = s.ctl[0][`DACC_B_GRP];
        if (grouped) begin
            all_written = ((s.pend | wr_dat) == 2'b11);
            case (s.ctl[0][`DACC_B_LSEL_HI:`DACC_B_LSEL_LO])
                `DACC_LSEL_WRITE: grp_trig = |wr_dat;
                `DACC_LSEL_GROUP: grp_trig = all_written;
                `DACC_LSEL_TMR1: grp_trig = rise1;
                `DACC_LSEL_TMR2: grp_trig = rise2;
                default: grp_trig = 1'b0;
            endcase
            load = {2{grp_trig & chan_enabled(s.ctl[0])}};
            if (s.ctl[0][`DACC_B_LSEL_HI:`DACC_B_LSEL_LO] == `DACC_LSEL_GROUP) begin
                next_s.pend = all_written ? 2'b00 : (s.pend | wr_dat);
            end else begin
                next_s.pend = 2'b00;
            end
        end else begin
            next_s.pend = 2'b00;
            for (int i = 0; i < 2; i++) begin
                load[i] = chan_enabled(s.ctl[i]) &
                          chan_trig(s.ctl[i], wr_dat[i], rise1, rise2);
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (load[i]) begin
                next_s.latch[i] = next_s.dat[i];
                // set wins over a clear in the same cycle
                next_s.ctl[i][`DACC_B_IFG] = 1'b1;
            end
            flags[i] = next_s.ctl[i][`DACC_B_IFG];
            next_s.chan_irq[i] = flags[i] & next_s.ctl[i][`DACC_B_IE];
        end
        next_s.irq = |(next_s.chan_irq & next_s.mask);
        next_s.core = core_dec;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
            s.ctl <= {2{`DACC_CTL_RST}};
            s.dat <= {2{`DACC_DAT_RST}};
            s.mask <= `DACC_MASK_RST;
            s.core[0].out_hiz <= 1'b1;
            s.core[1].out_hiz <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
    assign irq_out = s.irq;
    assign chan_irq_out = s.chan_irq;
    assign core_out = s.core;
endmodule

// ==== tb/dacc_core_model.sv ====
// Purpose: analog core stand-in for the channel control block
// Assumes: core word registered by the block
// Notes: level is the offset-binary code, zero while powered down
module dacc_core_model
    import dacc_pkg::*;
(
    input wire dacc_core_t [1:0] core_in,
    output logic [1:0][11:0] level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            level_out[i] = (core_in[i].in_spd == DACC_SPD_OFF) ? 12'h000 : core_in[i].code;
        end
    end
endmodule

// ==== tb/dacc_top_asserts.sv ====
// Purpose: port-level properties of the converter channel control block
// Assumes: one clock domain, reset active low
// Notes: bound into dacc_top
`include "dacc_defs.svh"
module dacc_top_asserts
    import dacc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic first_timer_out1_in,
    input wire logic second_timer_out2_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic irq_out,
    input wire logic [1:0] chan_irq_out,
    input wire dacc_core_t [1:0] core_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_hiz_off;
        core_out[0].out_hiz |-> core_out[0].in_spd == DACC_SPD_OFF
            && core_out[0].out_spd == DACC_SPD_OFF && !core_out[0].out_zero;
    endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("high-z with buffers on");
    property p_off_state;
        core_out[0].in_spd == DACC_SPD_OFF |-> core_out[0].out_spd == DACC_SPD_OFF
            && (core_out[0].out_hiz || core_out[0].out_zero);
    endproperty
    a_off_state: assert property (p_off_state) else $error("off state malformed");
    property p_spd_order;
        core_out[0].in_spd != DACC_SPD_OFF |-> core_out[0].out_spd >= core_out[0].in_spd
            && !core_out[0].out_hiz && !core_out[0].out_zero;
    endproperty
    a_spd_order: assert property (p_spd_order) else $error("speed pair illegal");
    property p_res8;
        core_out[0].res_8bit |-> core_out[0].code[11:8] == 4'h0;
    endproperty
    a_res8: assert property (p_res8) else $error("8-bit code upper bits set");
    property p_dat_read;
        pready_out && !pwrite_in && paddr_in == `DACC_OFF_DAT0 |-> prdata_out[31:12] == 20'h0;
    endproperty
    a_dat_read: assert property (p_dat_read) else $error("sample upper bits not zero");
    property p_irq_or;
        irq_out |-> |chan_irq_out;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq without channel request");
    property p_cal_hold;
        $rose(core_out[0].cal_active) |=> core_out[0].cal_active [*8];
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("calibration ended early");
    property p_err_zero;
        pslverr_out |-> pready_out && prdata_out == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error response malformed");
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_ready_wait;
        $rose(psel_in && penable_in) |=> pready_out;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
endmodule

bind dacc_top dacc_top_asserts u_asserts (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .first_timer_out1_in(first_timer_out1_in),
    .second_timer_out2_in(second_timer_out2_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
    .chan_irq_out(chan_irq_out), .core_out(core_out));

// ==== tb/test_dac_channel_control_logic.sv ====
// Purpose: self-checking bench for the converter channel control block
// Assumes: 10 MHz clock, APB slave with one wait state
// Notes: table rows cover amplifier codes and data formats
`include "dacc_defs.svh"
module test_dac_channel_control_logic
    import dacc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [15:0] ctl;
        logic [11:0] dat;
        logic [11:0] code;
        logic [5:0] spd;
    } dacc_row_t;
    logic clk, nrst, psel, penable, pwrite, t1, t2, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cirq;
    dacc_core_t [1:0] core;
    logic [1:0][11:0] lvl;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    dacc_row_t rows [8] = '{
        {16'h0000, 12'h123, 12'h123, 6'h02}, {16'h0020, 12'hABC, 12'hABC, 6'h01},
        {16'h0040, 12'h800, 12'h800, 6'h14}, {16'h0070, 12'h800, 12'h000, 6'h18},
        {16'h0090, 12'h7FF, 12'hFFF, 6'h1C}, {16'h10A0, 12'hFA5, 12'h0A5, 6'h28},
        {16'h10D0, 12'hF85, 12'h005, 6'h2C}, {16'h00E0, 12'hFFF, 12'hFFF, 6'h3C}};

    dacc_top DUT (.sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .first_timer_out1_in(t1),
        .second_timer_out2_in(t2), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq), .chan_irq_out(cirq), .core_out(core));
    dacc_core_model u_core (.core_in(core), .level_out(lvl));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 1) t1 <= 1'b1;
        else t2 <= 1'b1;
        @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        settle();
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        t1 = 1'b0;
        t2 = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, `DACC_OFF_CTL0, {16'h0000, rows[i].ctl});
            apb(1'b1, `DACC_OFF_DAT0, {20'h00000, rows[i].dat});
            settle();
            chk("code", {20'h0, core[0].code}, {20'h0, rows[i].code});
            chk("speed", {26'h0, core[0].in_spd, core[0].out_spd, core[0].out_hiz,
                core[0].out_zero}, {26'h0, rows[i].spd});
            chk("level", {20'h0, lvl[0]}, rows[i].spd[5:4] == 2'b00 ? 32'h0 : rows[i].code);
            chk("core_cfg", {28'h0, core[0].ref_sel, core[0].range_3x, core[0].res_8bit},
                {28'h0, rows[i].ctl[14:13], ~rows[i].ctl[8], rows[i].ctl[12]});
            chk("no_irq", {31'h0, cirq[0]}, 32'h0);
        end
        // upper sample bits and unmapped address
        apb(1'b1, `DACC_OFF_DAT0, 32'hFFFF_F123);
        apb(1'b0, `DACC_OFF_DAT0, 32'h0);
        chk("dat_rd", rd, 32'h0000_0123);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        // interrupt raise, mask, clear
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0008);
        apb(1'b1, `DACC_OFF_DAT0, 32'h0000_0055);
        settle();
        chk("irq", {30'h0, irq, cirq[0]}, 32'h3);
        apb(1'b0, `DACC_OFF_CTL0, 32'h0);
        chk("flag", {31'h0, rd[2]}, 32'h1);
        apb(1'b1, `DACC_OFF_MASK, 32'h0);
        settle();
        chk("masked", {30'h0, irq, cirq[0]}, 32'h1);
        apb(1'b1, `DACC_OFF_STAT, 32'h1);
        apb(1'b1, `DACC_OFF_MASK, 32'h3);
        settle();
        chk("cleared", {30'h0, irq, cirq[0]}, 32'h0);
        // timer triggers, enable gating and locked fields
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0800);
        apb(1'b1, `DACC_OFF_DAT0, 32'h0000_0456);
        pulse(1);
        chk("enc_off", {20'h0, core[0].code}, 32'h055);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0802);
        pulse(1);
        chk("tmr1", {20'h0, core[0].code}, 32'h456);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_1C12);
        apb(1'b0, `DACC_OFF_CTL0, 32'h0);
        chk("locked", rd & 32'hFFFF_FFFB, 32'h0000_0802);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0C02);
        apb(1'b1, `DACC_OFF_DAT0, 32'h0000_0789);
        pulse(1);
        chk("tmr2_wait", {20'h0, core[0].code}, 32'h456);
        pulse(2);
        chk("tmr2", {20'h0, core[0].code}, 32'h789);
        // grouped load waits for both data registers
        apb(1'b1, `DACC_OFF_CTL0, 32'h0);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0403);
        apb(1'b1, `DACC_OFF_DAT0, 32'h0000_0111);
        settle();
        chk("grp_wait", {20'h0, core[0].code}, 32'h789);
        apb(1'b1, `DACC_OFF_DAT1, 32'h0000_0222);
        settle();
        chk("grp0", {20'h0, core[0].code}, 32'h111);
        chk("grp1", {20'h0, core[1].code}, 32'h222);
        // calibration self-clears
        apb(1'b1, `DACC_OFF_CTL0, 32'h0);
        apb(1'b1, `DACC_OFF_CTL0, 32'h0000_0200);
        settle();
        chk("cal_on", {31'h0, core[0].cal_active}, 32'h1);
        repeat (1010) @(posedge clk);
        apb(1'b0, `DACC_OFF_CTL0, 32'h0);
        chk("cal_off", {31'h0, rd[9]}, 32'h0);
        // top channel's group bit has no effect
        apb(1'b1, `DACC_OFF_CTL1, 32'h0000_0009);
        apb(1'b1, `DACC_OFF_DAT1, 32'h0000_0333);
        settle();
        chk("ch1_code", {20'h0, core[1].code}, 32'h333);
        chk("ch0_kept", {20'h0, core[0].code}, 32'h111);
        chk("ch1_irq", {29'h0, irq, cirq}, 32'h6);
        // reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        settle();
        chk("rst_out", {30'h0, core[0].out_hiz, irq}, 32'h2);
        nrst <= 1'b1;
        apb(1'b0, `DACC_OFF_CTL0, 32'h0);
        chk("rst_ctl", rd, 32'h0);
        apb(1'b0, `DACC_OFF_MASK, 32'h0);
        chk("rst_mask", rd, 32'h3);
        end_of_test();
    end
endmodule
